// [verilog/rtccd_top.sv]
// Counter value, clock source and debug control registers of a 16-bit
// real-time counter, reached by software over Avalon-MM.
// Assumes a word-addressed Avalon master and slow asynchronous clock pins.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

`include "rtccd_params.svh"

module rtccd_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        cpu_halted_i,
  input  wire logic        ulp_osc_i,
  input  wire logic        ext_clk_i,
  output logic [15:0]      rtc_count_o,
  output logic             count_sync_busy_o
);

  rtccd_pkg::rtccd_top_s st_r;
  rtccd_pkg::rtccd_top_s st_nxt;
  logic                  tick;
  logic                  advance;
  logic                  accept;
  logic                  wr_en;
  logic [7:0]            wbyte;
  logic                  busy;

  rtccd_tick_sel u_tick (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .clk_sel_i (st_r.clk_sel),
    .ulp_osc_i (ulp_osc_i),
    .ext_clk_i (ext_clk_i),
    .tick_o    (tick)
  );

  // ========================================================================
  // Bus handshake
  // Every request gets exactly one wait state, so the answer is a register
  // and the read data are stable at the edge where waitrequest is low.
  assign accept  = (avs_read_i | avs_write_i) & ~st_r.waitreq;
  assign wr_en   = accept & avs_write_i & avs_byteenable_i[0];
  assign wbyte   = avs_writedata_i[7:0];
  assign busy    = (st_r.fsm != rtccd_pkg::SYNC_IDLE);
  // Halt only gates counting; the write crossing still completes.
  assign advance = tick & ~(cpu_halted_i & ~st_r.dbg_run);

  // ========================================================================
  // Next state
  always_comb begin
    st_nxt         = st_r;
    st_nxt.waitreq = 1'b1;
    if ((avs_read_i | avs_write_i) & st_r.waitreq) begin
      st_nxt.waitreq = 1'b0;
      st_nxt.rdata   = 32'h0000_0000;
      if (avs_read_i) begin
        if (avs_address_i == `RTCCD_IDX_STATUS) begin
          st_nxt.rdata[`RTCCD_BIT_BUSY] = busy;
        end else if (avs_address_i == `RTCCD_IDX_TEMP) begin
          st_nxt.rdata[7:0] = st_r.temp;
        end else if (avs_address_i == `RTCCD_IDX_DBGCTL) begin
          st_nxt.rdata[`RTCCD_BIT_DEBUG_RUN_ENABLE] = st_r.dbg_run;
        end else if (avs_address_i == `RTCCD_IDX_CLKSRC) begin
          st_nxt.rdata[1:0] = st_r.clk_sel;
        end else if (avs_address_i == `RTCCD_IDX_CNT_LO) begin
          st_nxt.rdata[7:0] = st_r.cnt[7:0];
        end else if (avs_address_i == `RTCCD_IDX_CNT_HI) begin
          st_nxt.rdata[7:0] = st_r.temp;
        end
      end
    end

    // Counter: a finished write load wins over an advance in the same tick.
    if (advance) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
    case (st_r.fsm)
      rtccd_pkg::SYNC_ONE: begin
        if (tick) begin
          st_nxt.fsm = rtccd_pkg::SYNC_TWO;
        end
      end
      rtccd_pkg::SYNC_TWO: begin
        if (tick) begin
          st_nxt.cnt = st_r.pend;
          st_nxt.fsm = rtccd_pkg::SYNC_IDLE;
        end
      end
      default: begin
        st_nxt.fsm = rtccd_pkg::SYNC_IDLE;
      end
    endcase

    // The high byte is snapshot in the cycle the low byte is captured, so a
    // tick between capture and answer cannot tear the pair.
    if (avs_read_i & st_r.waitreq & (avs_address_i == `RTCCD_IDX_CNT_LO)) begin
      st_nxt.temp = st_r.cnt[15:8];
    end

    if (wr_en) begin
      if (avs_address_i == `RTCCD_IDX_TEMP) begin
        st_nxt.temp = wbyte;
      end else if (avs_address_i == `RTCCD_IDX_DBGCTL) begin
        st_nxt.dbg_run = wbyte[`RTCCD_BIT_DEBUG_RUN_ENABLE];
      end else if (avs_address_i == `RTCCD_IDX_CLKSRC) begin
        // The reserved code is never stored, so the source stays valid.
        if (wbyte[1:0] != `RTCCD_SEL_RSVD) begin
          st_nxt.clk_sel = wbyte[1:0];
        end
      end else if (avs_address_i == `RTCCD_IDX_CNT_LO) begin
        st_nxt.temp = wbyte;
      end else if (avs_address_i == `RTCCD_IDX_CNT_HI) begin
        // A write while busy restarts the crossing with the newer value.
        st_nxt.pend = {wbyte, st_r.temp};
        st_nxt.fsm  = rtccd_pkg::SYNC_ONE;
      end
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r.waitreq <= 1'b1;
      st_r.rdata   <= 32'h0000_0000;
      st_r.dbg_run <= 1'b0;
      st_r.clk_sel <= `RTCCD_RST_SEL;
      st_r.temp    <= `RTCCD_RST_BYTE;
      st_r.cnt     <= `RTCCD_RST_CNT;
      st_r.pend    <= `RTCCD_RST_CNT;
      st_r.ticks   <= 2'h0;
      st_r.fsm     <= rtccd_pkg::SYNC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Busy output is the fsm decoded; registered copy keeps outputs on flops.
  logic busy_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (st_nxt.fsm != rtccd_pkg::SYNC_IDLE);
    end
  end

  assign avs_readdata_o    = st_r.rdata;
  assign avs_waitrequest_o = st_r.waitreq;
  assign rtc_count_o       = st_r.cnt;
  assign count_sync_busy_o = busy_r;

endmodule

`default_nettype wire

// [verilog/rtccd_params.svh]
// Constants for the counter clock, debug and count register slice.
// Assumes inclusion by bare name from the design files of this block.
`ifndef RTCCD_PARAMS_SVH
`define RTCCD_PARAMS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define RTCCD_IDX_STATUS   5'h01
`define RTCCD_IDX_TEMP     5'h04
`define RTCCD_IDX_DBGCTL   5'h05
`define RTCCD_IDX_CLKSRC   5'h07
`define RTCCD_IDX_CNT_LO   5'h08
`define RTCCD_IDX_CNT_HI   5'h09

// ==========================================================================
// Field positions and reset values
`define RTCCD_BIT_BUSY     1
`define RTCCD_BIT_DEBUG_RUN_ENABLE   0
`define RTCCD_RST_BYTE     8'h00
`define RTCCD_RST_CNT      16'h0000
`define RTCCD_RST_SEL      2'h0

// ==========================================================================
// Clock source encodings and timing counts
`define RTCCD_SEL_32K      2'h0
`define RTCCD_SEL_1K       2'h1
`define RTCCD_SEL_RSVD     2'h2
`define RTCCD_SEL_EXT      2'h3
`define RTCCD_DIV_1K_LAST  5'h1F
`define RTCCD_SYNC_TICKS   2'h2

`endif

// [verilog/rtccd_pkg.sv]
// Types shared by the counter clock, debug and count register slice.
// Assumes the constants header is compiled alongside.
package rtccd_pkg;

  // ========================================================================
  // Write synchroniser states
  typedef enum logic [2:0] {
    SYNC_IDLE = 3'h1,
    SYNC_ONE  = 3'h2,
    SYNC_TWO  = 3'h4
  } rtccd_sync_e;

  // ========================================================================
  // State of the tick selector
  typedef struct packed {
    logic       osc_prev;
    logic       ext_prev;
    logic [4:0] div;
    logic       tick;
  } rtccd_tick_s;

  // ========================================================================
  // State of the top module
  typedef struct packed {
    logic        waitreq;
    logic [31:0] rdata;
    logic        dbg_run;
    logic [1:0]  clk_sel;
    logic [7:0]  temp;
    logic [15:0] cnt;
    logic [15:0] pend;
    logic [1:0]  ticks;
    rtccd_sync_e fsm;
  } rtccd_top_s;

endpackage

// [verilog/rtccd_sync.sv]
// Two flip-flop level synchroniser for pins from outside the clock domain.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/1ns
`default_nettype none

module rtccd_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic [1:0] state_r;
  logic [1:0] state_nxt;

  // ========================================================================
  // Stage one is read only by stage two.
  always_comb begin
    state_nxt = {state_r[0], async_i};
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_o = state_r[1];

endmodule

`default_nettype wire

// [verilog/rtccd_tick_sel.sv]
// Counter clock source selection, producing one-cycle tick enables.
// Assumes the oscillator and external pin are far slower than clk_i.
`timescale 1ns/1ns
`default_nettype none

`include "rtccd_params.svh"

module rtccd_tick_sel (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] clk_sel_i,
  input  wire logic       ulp_osc_i,
  input  wire logic       ext_clk_i,
  output logic            tick_o
);

  rtccd_pkg::rtccd_tick_s st_r;
  rtccd_pkg::rtccd_tick_s st_nxt;
  logic                   osc_s;
  logic                   ext_s;
  logic                   osc_rise;

  rtccd_sync u_sync_osc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (ulp_osc_i),
    .sync_o  (osc_s)
  );

  rtccd_sync u_sync_ext (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (ext_clk_i),
    .sync_o  (ext_s)
  );

  assign osc_rise = osc_s & ~st_r.osc_prev;

  // ========================================================================
  // Source select; the reserved code yields no ticks at all.
  always_comb begin
    st_nxt          = st_r;
    st_nxt.osc_prev = osc_s;
    st_nxt.ext_prev = ext_s;
    st_nxt.tick     = 1'b0;
    if (osc_rise) begin
      st_nxt.div = st_r.div + 5'h01;
    end
    if (clk_sel_i == `RTCCD_SEL_32K) begin
      st_nxt.tick = osc_rise;
    end else if (clk_sel_i == `RTCCD_SEL_1K) begin
      st_nxt.tick = osc_rise && (st_r.div == `RTCCD_DIV_1K_LAST);
    end else if (clk_sel_i == `RTCCD_SEL_EXT) begin
      st_nxt.tick = ext_s & ~st_r.ext_prev;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

endmodule

`default_nettype wire

// [test/rtccd_chk.sv]
// Checker for the counter value, clock source and debug register slice.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module rtccd_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        cpu_halted_i,
  input wire logic        ulp_osc_i,
  input wire logic        ext_clk_i,
  input wire logic [15:0] rtc_count_o,
  input wire logic        count_sync_busy_o
);
  logic       wr_a;
  logic       rd_a;
  logic       dbg_r;
  logic [1:0] sel_r;
  assign wr_a = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign rd_a = avs_read_i && !avs_waitrequest_o;
  // Shadow copies let the readback checks stand apart from bench stimulus.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dbg_r <= 1'b0;
      sel_r <= 2'h0;
    end else if (wr_a) begin
      if (avs_address_i == 5'h05) dbg_r <= avs_writedata_i[0];
      if (avs_address_i == 5'h07 && avs_writedata_i[1:0] != 2'h2) sel_r <= avs_writedata_i[1:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_hi_write;
    wr_a && avs_address_i == 5'h09;
  endsequence
  a_wait_one_state: assert property (s_req_wait |=> !avs_waitrequest_o)
    else $error("answer not given after one wait state");
  a_wait_low_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_rdata_upper_zero: assert property (rd_a |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_halt_count_freeze: assert property (cpu_halted_i && !dbg_r && !count_sync_busy_o
    |=> $stable(rtc_count_o))
    else $error("count moved while halted");
  a_count_step_one: assert property ($changed(rtc_count_o) && !$fell(count_sync_busy_o)
    |-> rtc_count_o == $past(rtc_count_o) + 16'h1)
    else $error("count advanced by other than one");
  a_busy_on_write: assert property (s_hi_write |=> count_sync_busy_o)
    else $error("busy not set after high byte write");
  a_sel_readback: assert property (rd_a && avs_address_i == 5'h07
    |-> avs_readdata_o == {30'h0, sel_r})
    else $error("clock select readback wrong");
  a_dbg_readback: assert property (rd_a && avs_address_i == 5'h05
    |-> avs_readdata_o == {31'h0, dbg_r})
    else $error("debug control readback wrong");
endmodule

bind rtccd_top rtccd_chk chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .cpu_halted_i(cpu_halted_i), .ulp_osc_i(ulp_osc_i),
  .ext_clk_i(ext_clk_i), .rtc_count_o(rtc_count_o), .count_sync_busy_o(count_sync_busy_o)
);

`default_nettype wire

// [test/tb_rtc_clock_debug_count_regs.sv]
// Self-checking bench for the counter value, clock source and debug slice.
// Assumes the checker is bound to the top module in its own file.
`timescale 1ns/1ns
`default_nettype none

module tb_rtc_clock_debug_count_regs;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'hF;
  logic        halt = 1'b0;
  logic        osc = 1'b0;
  logic        ext = 1'b0;
  logic [31:0] rdat;
  logic        wreq;
  logic [15:0] cnt;
  logic        busy;
  logic [15:0] exp_cnt = 16'h0;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #20 clk_i = ~clk_i;

  rtccd_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .cpu_halted_i(halt), .ulp_osc_i(osc), .ext_clk_i(ext),
    .rtc_count_o(cnt), .count_sync_busy_o(busy)
  );

  // ==========================================================================
  // Shared tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The request stands until waitrequest is sampled low at a rising edge;
  // read data are taken at that edge, and only then is the request released.
  // A hang is ended by the cycle watchdog, not here.
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wrb(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input string nm, input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, e}, q);
  endtask

  task automatic pulse(input logic on_ext, input int n);
    repeat (n) begin
      if (on_ext) ext <= 1'b1;
      else osc <= 1'b1;
      repeat (8) @(posedge clk_i);
      ext <= 1'b0;
      osc <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rc("debug ctrl", 5'h05, 8'h00);
    rc("clock sel", 5'h07, 8'h00);
    rc("count lo", 5'h08, 8'h00);
    rc("temp", 5'h04, 8'h00);
    rc("status", 5'h01, 8'h00);
    rc("unmapped", 5'h1F, 8'h00);
  endtask

  task automatic t_temp();
    be <= 4'hE;
    wrb(5'h04, 8'hA5);
    be <= 4'hF;
    rc("temp masked", 5'h04, 8'h00);
    wrb(5'h04, 8'h5A);
    rc("temp written", 5'h04, 8'h5A);
  endtask

  task automatic t_clock_source_select();
    wrb(5'h07, 8'h01);
    rc("sel one", 5'h07, 8'h01);
    wrb(5'h07, 8'h02);
    rc("sel reserved", 5'h07, 8'h01);
    wrb(5'h07, 8'h03);
    rc("sel three", 5'h07, 8'h03);
  endtask

  task automatic t_load();
    rc("busy idle", 5'h01, 8'h00);
    wrb(5'h08, 8'h34);
    wrb(5'h09, 8'h12);
    rc("busy set", 5'h01, 8'h02);
    // The counter keeps running while the written value crosses over.
    pulse(1'b1, 1);
    exp_cnt++;
    chk("count one tick", {16'h0, exp_cnt}, {16'h0, cnt});
    chk("busy one tick", 32'h1, {31'h0, busy});
    pulse(1'b1, 1);
    exp_cnt = 16'h1234;
    chk("count loaded", {16'h0, exp_cnt}, {16'h0, cnt});
    chk("busy cleared", 32'h0, {31'h0, busy});
    rc("read lo", 5'h08, 8'h34);
    rc("read hi", 5'h09, 8'h12);
    rc("temp latched", 5'h04, 8'h12);
  endtask

  task automatic t_sources();
    pulse(1'b1, 1);
    exp_cnt++;
    chk("ext tick", {16'h0, exp_cnt}, {16'h0, cnt});
    wrb(5'h07, 8'h00);
    pulse(1'b0, 1);
    exp_cnt++;
    chk("osc tick", {16'h0, exp_cnt}, {16'h0, cnt});
    wrb(5'h07, 8'h01);
    pulse(1'b0, 32);
    exp_cnt++;
    chk("divided tick", {16'h0, exp_cnt}, {16'h0, cnt});
  endtask

  task automatic t_debug();
    wrb(5'h07, 8'h03);
    halt <= 1'b1;
    pulse(1'b1, 2);
    chk("halted frozen", {16'h0, exp_cnt}, {16'h0, cnt});
    wrb(5'h05, 8'h01);
    rc("debug run", 5'h05, 8'h01);
    pulse(1'b1, 1);
    exp_cnt++;
    chk("halted running", {16'h0, exp_cnt}, {16'h0, cnt});
    halt <= 1'b0;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_temp();
    t_clock_source_select();
    t_load();
    t_sources();
    t_debug();
    end_sim();
  end
endmodule

`default_nettype wire
